// File: core/rx_path_timeout_monitor_pkg.sv
package rx_path_timeout_monitor_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int NUM_PATHS = 4;
   localparam int PATH_W = 2;
   localparam int MBX_BYTES = 8;
   localparam int SLAVE_W = 5;
   localparam int NUM_SLAVES = 32;
   localparam int TMO_W = 32;
   localparam int CHK_HDR_SINGLE = 1;
   localparam int CHK_HDR_BCAST = 2;
   localparam logic [TMO_W-1:0] TMO_RESET = 32'h0000_0000;
   localparam logic [7:0] BYTE_CLEAR = 8'h00;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef logic [MBX_BYTES-1:0][7:0] mbx_t;

   typedef struct packed {
      logic valid;
      logic crc_ok;
      logic from_master;
      logic broadcast;
      logic [PATH_W-1:0] path;
      logic [15:0] check_info;
      mbx_t data;
   } rx_msg_t;

   typedef struct packed {
      logic [NUM_PATHS-1:0][TMO_W-1:0] cnt;
      logic [NUM_PATHS-1:0] fault;
      logic [NUM_PATHS-1:0] seen;
      logic [NUM_PATHS-1:0][MBX_BYTES-1:0][7:0] mbx_a;
      logic [NUM_PATHS-1:0][MBX_BYTES-1:0][7:0] mbx_b;
      logic [NUM_SLAVES-1:0] src_err;
      logic [NUM_PATHS-1:0] accept_p;
      logic [NUM_PATHS-1:0] expire_p;
   } mon_state_t;
endpackage : rx_path_timeout_monitor_pkg

// File: core/rx_path_timeout_monitor.sv
`timescale 1ns/1ps
module rx_path_timeout_monitor (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [rx_path_timeout_monitor_pkg::TMO_W-1:0] safety_timeout,
   input wire logic [rx_path_timeout_monitor_pkg::NUM_PATHS-1:0] path_enable,
   input wire logic [rx_path_timeout_monitor_pkg::NUM_PATHS-1:0][rx_path_timeout_monitor_pkg::SLAVE_W-1:0] path_src,
   input wire rx_path_timeout_monitor_pkg::rx_msg_t msg_a,
   input wire rx_path_timeout_monitor_pkg::rx_msg_t msg_b,
   input wire logic mailbox_path_check,
   input wire logic [rx_path_timeout_monitor_pkg::PATH_W-1:0] check_path,
   input wire logic [rx_path_timeout_monitor_pkg::NUM_SLAVES-1:0] err_clear,
   output logic [rx_path_timeout_monitor_pkg::NUM_PATHS-1:0][rx_path_timeout_monitor_pkg::MBX_BYTES-1:0][7:0] mbx_a,
   output logic [rx_path_timeout_monitor_pkg::NUM_PATHS-1:0][rx_path_timeout_monitor_pkg::MBX_BYTES-1:0][7:0] mbx_b,
   output logic [rx_path_timeout_monitor_pkg::NUM_PATHS-1:0] path_fault,
   output logic [rx_path_timeout_monitor_pkg::NUM_SLAVES-1:0] src_err,
   output logic [rx_path_timeout_monitor_pkg::NUM_PATHS-1:0] accept_pulse,
   output logic [rx_path_timeout_monitor_pkg::NUM_PATHS-1:0] expire_pulse
);
   rx_path_timeout_monitor_pkg::mon_state_t s_q;
   rx_path_timeout_monitor_pkg::mon_state_t s_d;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic good_a;
      logic good_b;
      logic tmo_hit;
      good_a = 1'b0;
      good_b = 1'b0;
      tmo_hit = 1'b0;
      s_d = s_q;
      s_d.accept_p = '0;
      s_d.expire_p = '0;
      s_d.src_err = s_q.src_err & ~err_clear;
      for (int p = 0; p < rx_path_timeout_monitor_pkg::NUM_PATHS; p++) begin
         good_a = msg_a.valid && msg_a.crc_ok && !msg_a.from_master && (int'(msg_a.path) == p);
         good_b = msg_b.valid && msg_b.crc_ok && !msg_b.from_master && (int'(msg_b.path) == p);
         if (!path_enable[p]) begin
            s_d.cnt[p] = safety_timeout;
            s_d.seen[p] = 1'b0;
         end else if (good_a || good_b) begin
            s_d.cnt[p] = safety_timeout;
            s_d.seen[p] = 1'b1;
            s_d.fault[p] = 1'b0;
            s_d.accept_p[p] = 1'b1;
         end else begin
            tmo_hit = (s_q.cnt[p] <= 32'h0000_0001);
            if (tmo_hit && !s_q.fault[p]) begin
               s_d.fault[p] = 1'b1;
               s_d.expire_p[p] = 1'b1;
               s_d.mbx_a[p] = '0;
               s_d.mbx_b[p] = '0;
               s_d.src_err[path_src[p]] = 1'b1;
            end else if (!tmo_hit) begin
               s_d.cnt[p] = s_q.cnt[p] - 32'h0000_0001;
            end
         end
         if (good_a) begin
            s_d.mbx_a[p] = msg_a.data;
            s_d.mbx_a[p][0] = msg_a.check_info[7:0];
            if (msg_a.broadcast) begin
               s_d.mbx_a[p][1] = msg_a.check_info[15:8];
            end
         end
         if (good_b) begin
            s_d.mbx_b[p] = msg_b.data;
            s_d.mbx_b[p][0] = msg_b.check_info[7:0];
            if (msg_b.broadcast) begin
               s_d.mbx_b[p][1] = msg_b.check_info[15:8];
            end
         end
         if (mailbox_path_check && (int'(check_path) == p) && s_q.fault[p]) begin
            s_d.mbx_b[p] = s_d.mbx_a[p];
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign mbx_a = s_q.mbx_a;
   assign mbx_b = s_q.mbx_b;
   assign path_fault = s_q.fault;
   assign src_err = s_q.src_err;
   assign accept_pulse = s_q.accept_p;
   assign expire_pulse = s_q.expire_p;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence bad_a_s(int p);
      msg_a.valid && !msg_a.crc_ok && int'(msg_a.path) == p && !(msg_b.valid && int'(msg_b.path) == p);
   endsequence

   for (genvar g = 0; g < rx_path_timeout_monitor_pkg::NUM_PATHS; g++) begin : g_chk
      a_expiry_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
         $rose(s_q.expire_p[g]) |-> s_q.mbx_a[g] == '0 && s_q.mbx_b[g] == '0 && s_q.fault[g])
         else $error("mailbox not cleared at expiry");
      a_expiry_srcbit: assert property (@(posedge clk_sys) disable iff (!rstn)
         s_q.expire_p[g] |-> s_q.src_err[path_src[g]])
         else $error("source bit not set");
      a_bad_keeps: assert property (@(posedge clk_sys) disable iff (!rstn)
         bad_a_s(g) ##0 !(s_q.fault[g] == 1'b0 && s_q.cnt[g] <= 32'h0000_0001) && !mailbox_path_check
         |=> s_q.mbx_a[g] == $past(s_q.mbx_a[g]))
         else $error("errored frame altered mailbox");
      a_valid_accept: assert property (@(posedge clk_sys) disable iff (!rstn)
         path_enable[g] && msg_a.valid && msg_a.crc_ok && !msg_a.from_master && int'(msg_a.path) == g
         |=> s_q.accept_p[g] && !s_q.fault[g])
         else $error("valid frame not accepted");
      a_master_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
         msg_a.valid && msg_a.from_master && !msg_b.valid |=> !s_q.accept_p[g])
         else $error("master frame accepted");
      a_reload_value: assert property (@(posedge clk_sys) disable iff (!rstn)
         s_q.accept_p[g] |-> s_q.cnt[g] == $past(safety_timeout))
         else $error("counter not reloaded");
      a_countdown: assert property (@(posedge clk_sys) disable iff (!rstn)
         path_enable[g] && $past(path_enable[g]) && !s_q.accept_p[g] && s_q.cnt[g] > 32'h0000_0001
         && !$past(s_q.accept_p[g]) |-> s_q.cnt[g] < $past(s_q.cnt[g]) || $past(s_q.fault[g]))
         else $error("counter not running");
      a_copy_b: assert property (@(posedge clk_sys) disable iff (!rstn)
         mailbox_path_check && int'(check_path) == g && s_q.fault[g] && !msg_a.valid && !msg_b.valid
         |=> s_q.mbx_b[g] == s_q.mbx_a[g])
         else $error("channel A not copied");
   end

   // ----------------------------------------
   // Further checks
   // ----------------------------------------
   sequence good_a_s(int p);
      msg_a.valid && msg_a.crc_ok && !msg_a.from_master && int'(msg_a.path) == p;
   endsequence

   sequence master_a_s(int p);
      msg_a.valid && msg_a.from_master && int'(msg_a.path) == p && !msg_b.valid;
   endsequence

   for (genvar g = 0; g < rx_path_timeout_monitor_pkg::NUM_PATHS; g++) begin : g_more
      a_disabled_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
         !path_enable[g] |=> s_q.cnt[g] == $past(safety_timeout))
         else $error("disabled path not at shared timeout");

      a_valid_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
         path_enable[g] ##0 good_a_s(g) |=> !s_q.fault[g])
         else $error("valid frame left fault set");

      a_header_byte: assert property (@(posedge clk_sys) disable iff (!rstn)
         good_a_s(g) |=> s_q.mbx_a[g][0] == $past(msg_a.check_info[7:0]))
         else $error("check byte not in first byte");

      a_bcast_header: assert property (@(posedge clk_sys) disable iff (!rstn)
         good_a_s(g) ##0 msg_a.broadcast |=> s_q.mbx_a[g][1] == $past(msg_a.check_info[15:8]))
         else $error("broadcast check byte missing");

      a_data_bytes: assert property (@(posedge clk_sys) disable iff (!rstn)
         good_a_s(g) |=> s_q.mbx_a[g][7:2] == $past(msg_a.data[7:2]))
         else $error("payload bytes not stored");

      a_single_expiry: assert property (@(posedge clk_sys) disable iff (!rstn)
         s_q.expire_p[g] |=> !s_q.expire_p[g])
         else $error("expiry repeated");

      a_fault_source: assert property (@(posedge clk_sys) disable iff (!rstn)
         $rose(s_q.fault[g]) |-> s_q.expire_p[g])
         else $error("fault without expiry");

      a_accept_enabled: assert property (@(posedge clk_sys) disable iff (!rstn)
         s_q.accept_p[g] |-> $past(path_enable[g]))
         else $error("accept on disabled path");

      a_master_counts: assert property (@(posedge clk_sys) disable iff (!rstn)
         master_a_s(g) ##0 path_enable[g] && s_q.cnt[g] > 32'h0000_0001
         |=> s_q.cnt[g] == $past(s_q.cnt[g]) - 32'h0000_0001)
         else $error("master frame reloaded counter");

      a_bad_counts: assert property (@(posedge clk_sys) disable iff (!rstn)
         bad_a_s(g) ##0 path_enable[g] && s_q.cnt[g] > 32'h0000_0001
         |=> s_q.cnt[g] == $past(s_q.cnt[g]) - 32'h0000_0001)
         else $error("errored frame reloaded counter");
   end
endmodule : rx_path_timeout_monitor

// File: bench/peer_node_model.sv
`timescale 1ns/1ps
module peer_node_model (
   input wire logic clk_sys,
   input wire logic req,
   input wire rx_path_timeout_monitor_pkg::rx_msg_t frm,
   output rx_path_timeout_monitor_pkg::rx_msg_t msg
);
   // Idle lines invert their previous value each cycle, never valid
   initial msg = '0;
   always @(negedge clk_sys) begin
      msg <= req ? frm : {1'b0, ~msg[$bits(msg)-2:0]};
   end
endmodule : peer_node_model

// File: bench/test_rx_path_timeout_monitor.sv
`timescale 1ns/1ps
module test_rx_path_timeout_monitor;
   typedef struct packed {logic [1:0] p; rx_path_timeout_monitor_pkg::mbx_t d;} note_t;
   logic clk_sys = 0;
   logic rstn = 0;
   logic req = 0;
   logic chk = 0;
   logic [1:0] cpath = '0;
   logic [3:0] pen = '0;
   logic [3:0][4:0] psrc = '0;
   logic [31:0] seed = 32'h0000_C82E;
   logic [3:0][63:0] keep = '0;
   int fail_count = 0;
   int total_checks = 0;
   note_t q[$];
   note_t n;
   rx_path_timeout_monitor_pkg::rx_msg_t frm = '0;
   rx_path_timeout_monitor_pkg::rx_msg_t ma;
   logic [3:0][7:0][7:0] mbx_a, mbx_b;
   logic [3:0] pf, acc, ex;
   logic [31:0] serr;
   always #5 clk_sys = ~clk_sys;
   peer_node_model peer (.clk_sys(clk_sys), .req(req), .frm(frm), .msg(ma));
   rx_path_timeout_monitor dut (.clk_sys(clk_sys), .rstn(rstn), .safety_timeout(32'h0000_0028),
      .path_enable(pen), .path_src(psrc), .msg_a(ma), .msg_b('0), .mailbox_path_check(chk),
      .check_path(cpath), .err_clear('0), .mbx_a(mbx_a), .mbx_b(mbx_b), .path_fault(pf),
      .src_err(serr), .accept_pulse(acc), .expire_pulse(ex));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic cmp(input logic [65:0] got, input logic [65:0] want);
      total_checks++;
      if (got !== want) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask : cmp
   task automatic send(input logic [1:0] p, input logic ok, input logic mst, input logic bc, input logic cp);
      rx_path_timeout_monitor_pkg::mbx_t e;
      @(negedge clk_sys);
      seed = xs(seed);
      frm.data[7:4] = seed;
      seed = xs(seed);
      frm.data[3:0] = seed;
      frm.check_info = seed[31:16];
      frm.valid = 1'b1;
      frm.crc_ok = ok;
      frm.from_master = mst;
      frm.broadcast = bc;
      frm.path = p;
      e = frm.data;
      e[0] = frm.check_info[7:0];
      if (bc) begin
         e[1] = frm.check_info[15:8];
      end
      if (ok && !mst) begin
         q.push_back({p, e});
         keep[p] = e;
      end
      req <= 1'b1;
      @(negedge clk_sys);
      req <= 1'b0;
      chk <= cp;
      cpath <= p;
      @(negedge clk_sys);
      chk <= 1'b0;
   endtask : send
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   // ----------------------------------------
   // Watcher
   // ----------------------------------------
   always @(negedge clk_sys) begin
      for (int i = 0; i < 4; i++) begin
         if (acc[i] === 1'b1 || ex[i] === 1'b1) begin
            n = q.size() ? q.pop_front() : '1;
            cmp({n.p, n.d}, {i[1:0], mbx_a[i]});
         end
      end
   end
   initial begin
      #50000;
      fail_count++;
      test_done();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      rstn <= 1'b1;
      seed = xs(seed);
      psrc <= seed[19:0];
      @(negedge clk_sys);
      pen <= 4'b0011;
      for (int i = 0; i < 16; i++) begin
         send(2'(i & 1), 1'b1, 1'b0, i[2], 1'b0);
         @(negedge clk_sys);
      end
      cmp(serr, 0);
      $display("test accept done");
      send(2'd0, 1'b0, 1'b0, 1'b0, 1'b0);
      send(2'd0, 1'b1, 1'b1, 1'b0, 1'b0);
      cmp(mbx_a[0], keep[0]);
      send(2'd0, 1'b1, 1'b0, 1'b1, 1'b0);
      send(2'd1, 1'b1, 1'b0, 1'b0, 1'b0);
      q.push_back({2'd0, 64'h0});
      q.push_back({2'd1, 64'h0});
      repeat (50) @(negedge clk_sys);
      cmp(pf, 4'b0011);
      cmp({serr[psrc[0]], serr[psrc[1]]}, 2'b11);
      $display("test timeout done");
      send(2'd1, 1'b1, 1'b0, 1'b0, 1'b1);
      @(negedge clk_sys);
      cmp(mbx_b[1], keep[1]);
      cmp(q.size(), 0);
      $display("test copy done");
      test_done();
   end
endmodule : test_rx_path_timeout_monitor
